// ==== hdl/ccrl_pkg.sv ====
package ccrl_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int TDRP_US = 75;
  localparam int TDRP_CYCLES = (TDRP_US * 1000) / CLK_PERIOD_NS;
  localparam int DC_SRC_PCT = 50;
  localparam int TDRP_TRANS_NS = 1000;
  localparam int TDRP_TRANS_CYCLES = TDRP_TRANS_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 20;
  localparam int TRY_WAIT_CYCLES = 4000;

  // ************************************************************
  // encodings
  // ************************************************************
  localparam logic [1:0] CUR_DEFAULT = 2'h0;
  localparam logic [1:0] CUR_NONE = 2'h3;

  typedef enum logic [1:0] {
    CCRL_PREF_NONE,
    CCRL_PREF_SRC,
    CCRL_PREF_SNK
  } ccrl_pref_type;

endpackage : ccrl_pkg

// ==== hdl/ccrl_toggle_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// toggle timer signals
// ************************************************************
interface ccrl_toggle_if;
  logic run;
  logic src_phase;
  logic transition;
  logic period_end;

  modport timer (input run, output src_phase, output transition, output period_end);
  modport user (output run, input src_phase, input transition, input period_end);
endinterface : ccrl_toggle_if

`default_nettype wire

// ==== hdl/ccrl_toggle_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

module ccrl_toggle_timer #(
  parameter int PERIOD_CYCLES = ccrl_pkg::TDRP_CYCLES,
  parameter int SRC_PCT = ccrl_pkg::DC_SRC_PCT
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  ccrl_toggle_if.timer tg
);
  import ccrl_pkg::*;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD_CYCLES - 1);
  localparam logic [CNT_W-1:0] SRC_END = CNT_W'((PERIOD_CYCLES * SRC_PCT) / 100);
  localparam logic [CNT_W-1:0] TR_END = CNT_W'(TDRP_TRANS_CYCLES);

  logic [CNT_W-1:0] cnt;
  wire logic wrap = (cnt == LAST);

  // ************************************************************
  // free-running period counter
  // ************************************************************
  // free running counter
  always_ff @(posedge sys_clk) begin
    if (!rst_n || wrap) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + CNT_W'(1);
    end
  end

  assign tg.src_phase = (cnt < SRC_END);
  assign tg.transition = (cnt < TR_END) || ((cnt >= SRC_END) && (cnt < SRC_END + TR_END));
  assign tg.period_end = wrap;

endmodule : ccrl_toggle_timer

`default_nettype wire

// ==== hdl/ccrl_role_logic.sv ====
// Function
// - as sink, pull-downs on both cc pins
// - sink attach decided by vbus present together with rp seen on a cc pin
// - terminated cc pin (rp seen as sink, rd seen as source) selects superspeed mux orientation
// - detected source current tracked; load limit output follows it
// - pd communication enabled on the active cc pin when attached
// - source presentation starts with vbus switch off; terminations switch roles
// - toggle source/sink by period, duty and transition time until attach
// - source sees sink: enable vbus and vconn, stop toggling
// - sink sees vbus: stop toggling, stay sink
// - rp side is host and supplier; rd side is device and sink
// - prefer source: try source when destined sink
// - prefer sink: try sink when destined source
// - role try done once, only during initial connection
// - swaps acted on only after connection completes
// - power swap exchanges terminations and vbus direction
// - data swap changes data role only
// - vconn swap changes vconn supplier only
// - directed unattach waits for toggle period boundary
`timescale 1ns/1ps
`default_nettype none

module ccrl_role_logic #(
  parameter int PERIOD_CYCLES = ccrl_pkg::TDRP_CYCLES,
  parameter int SRC_PCT = ccrl_pkg::DC_SRC_PCT
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic drp_en,
  input wire ccrl_pkg::ccrl_pref_type pref,
  input wire logic vbus_present,
  input wire logic cc1_rp_seen,
  input wire logic cc2_rp_seen,
  input wire logic [1:0] cc1_rp_level,
  input wire logic [1:0] cc2_rp_level,
  input wire logic cc1_rd_seen,
  input wire logic cc2_rd_seen,
  input wire logic pd_capable,
  input wire logic force_unattach,
  input wire logic pr_swap_done,
  input wire logic dr_swap_done,
  input wire logic vconn_swap_done,
  output logic cc1_pull_down,
  output logic cc2_pull_down,
  output logic cc1_pull_up,
  output logic cc2_pull_up,
  output logic vbus_src_en,
  output logic vconn_en,
  output logic ss_flip,
  output logic [1:0] current_limit,
  output logic pd_en,
  output logic pd_cc2,
  output logic attached,
  output logic host_role,
  output logic power_src
);
  import ccrl_pkg::*;

  typedef enum logic [2:0] {
    CCRL_UNATT,
    CCRL_TRY_SRC,
    CCRL_TRY_SNK,
    CCRL_ATT_SRC,
    CCRL_ATT_SNK
  } ccrl_state_type;

  ccrl_state_type state;
  ccrl_state_type next_state;
  logic try_used;
  logic pend_unatt;
  logic [CNT_W-1:0] try_cnt;
  logic next_flip;
  logic [1:0] next_cur;

  ccrl_toggle_if tg ();

  // ************************************************************
  // toggle timer
  // ************************************************************
  ccrl_toggle_timer #(
    .PERIOD_CYCLES(PERIOD_CYCLES),
    .SRC_PCT(SRC_PCT)
  ) u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tg(tg)
  );

  // ************************************************************
  // decode
  // ************************************************************
  wire logic present_src = drp_en && tg.src_phase;
  wire logic sink_seen = cc1_rd_seen ^ cc2_rd_seen;
  wire logic rp_seen = cc1_rp_seen || cc2_rp_seen;
  wire logic try_over = (try_cnt == CNT_W'(TRY_WAIT_CYCLES));
  wire logic in_unatt = (state == CCRL_UNATT);
  wire logic swap_ok = (state == CCRL_ATT_SRC) || (state == CCRL_ATT_SNK);
  assign tg.run = in_unatt;

  // ************************************************************
  // connection state machine
  // ************************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      CCRL_UNATT: begin
        if (tg.transition) begin
          next_state = CCRL_UNATT;
        end else if (present_src && sink_seen) begin
          if (pref == CCRL_PREF_SNK && !try_used) begin
            next_state = CCRL_TRY_SNK;
          end else begin
            next_state = CCRL_ATT_SRC;
          end
        end else if (!present_src && vbus_present && rp_seen) begin
          if (drp_en && pref == CCRL_PREF_SRC && !try_used) begin
            next_state = CCRL_TRY_SRC;
          end else begin
            next_state = CCRL_ATT_SNK;
          end
        end
      end
      CCRL_TRY_SRC: begin
        if (sink_seen) begin
          next_state = CCRL_ATT_SRC;
        end else if (try_over) begin
          next_state = CCRL_UNATT;
        end
      end
      CCRL_TRY_SNK: begin
        if (vbus_present && rp_seen) begin
          next_state = CCRL_ATT_SNK;
        end else if (try_over) begin
          next_state = CCRL_UNATT;
        end
      end
      CCRL_ATT_SRC: begin
        if (!sink_seen) begin
          next_state = CCRL_UNATT;
        end else if (pr_swap_done) begin
          next_state = CCRL_ATT_SNK;
        end
      end
      CCRL_ATT_SNK: begin
        if (!vbus_present) begin
          next_state = CCRL_UNATT;
        end else if (pr_swap_done) begin
          next_state = CCRL_ATT_SRC;
        end
      end
    endcase
    if (pend_unatt && tg.period_end) begin
      next_state = CCRL_UNATT;
    end
  end

  assign next_flip = cc2_rp_seen && !cc1_rp_seen;
  assign next_cur = !rp_seen ? CUR_DEFAULT : (next_flip ? cc2_rp_level : cc1_rp_level);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= CCRL_UNATT;
      pend_unatt <= 1'b0;
    end else begin
      state <= next_state;
      pend_unatt <= force_unattach || (pend_unatt && !tg.period_end);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      try_used <= 1'b0;
      try_cnt <= '0;
    end else begin
      if (next_state == CCRL_TRY_SRC || next_state == CCRL_TRY_SNK) begin
        try_used <= 1'b1;
      end else if (next_state == CCRL_UNATT && state != CCRL_TRY_SRC && state != CCRL_TRY_SNK
                   && state != CCRL_UNATT) begin
        try_used <= 1'b0;
      end
      try_cnt <= (state == CCRL_TRY_SRC || state == CCRL_TRY_SNK) ? try_cnt + CNT_W'(1) : '0;
    end
  end

  // ************************************************************
  // role outputs
  // ************************************************************
  wire logic src_term = (next_state == CCRL_ATT_SRC) || (next_state == CCRL_TRY_SRC)
                        || ((next_state == CCRL_UNATT) && present_src);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cc1_pull_down <= 1'b1;
      cc2_pull_down <= 1'b1;
      cc1_pull_up <= 1'b0;
      cc2_pull_up <= 1'b0;
      vbus_src_en <= 1'b0;
      vconn_en <= 1'b0;
      ss_flip <= 1'b0;
      current_limit <= CUR_NONE;
      pd_en <= 1'b0;
      pd_cc2 <= 1'b0;
      attached <= 1'b0;
      host_role <= 1'b0;
      power_src <= 1'b0;
    end else begin
      cc1_pull_down <= !src_term;
      cc2_pull_down <= !src_term;
      cc1_pull_up <= src_term;
      cc2_pull_up <= src_term;
      vbus_src_en <= (next_state == CCRL_ATT_SRC);
      attached <= (next_state == CCRL_ATT_SRC) || (next_state == CCRL_ATT_SNK);
      power_src <= (next_state == CCRL_ATT_SRC);
      pd_en <= pd_capable && ((next_state == CCRL_ATT_SRC) || (next_state == CCRL_ATT_SNK));
      if (in_unatt || state == CCRL_TRY_SRC || state == CCRL_TRY_SNK) begin
        host_role <= (next_state == CCRL_ATT_SRC);
        vconn_en <= (next_state == CCRL_ATT_SRC);
        if (next_state == CCRL_ATT_SRC) begin
          ss_flip <= cc2_rd_seen;
          pd_cc2 <= cc2_rd_seen;
        end
      end else if (swap_ok && next_state == state) begin
        if (dr_swap_done) begin
          host_role <= !host_role;
        end
        if (vconn_swap_done) begin
          vconn_en <= !vconn_en;
        end
      end
      if (next_state == CCRL_UNATT) begin
        vconn_en <= 1'b0;
        host_role <= 1'b0;
      end
      if (next_state == CCRL_ATT_SNK && rp_seen) begin
        ss_flip <= next_flip;
        pd_cc2 <= next_flip;
      end
      current_limit <= (next_state == CCRL_ATT_SNK) ? next_cur : CUR_NONE;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_in_try;
    (state == CCRL_TRY_SRC) || (state == CCRL_TRY_SNK);
  endsequence

  sequence s_try_left;
    s_in_try ##1 (state == CCRL_UNATT);
  endsequence

  sequence s_pr_swap_snk;
    (state == CCRL_ATT_SNK) && vbus_present && pr_swap_done && !(pend_unatt && tg.period_end);
  endsequence

  property p_term_pairs;
    (cc1_pull_down == !cc1_pull_up) && (cc2_pull_down == !cc2_pull_up) && (cc1_pull_up == cc2_pull_up);
  endproperty
  a_term_pairs: assert property (p_term_pairs) else $error("terminations not paired");

  property p_snk_attach_vbus;
    ($rose(attached) && !power_src) |-> $past(vbus_present);
  endproperty
  a_snk_attach_vbus: assert property (p_snk_attach_vbus) else $error("sink attach without vbus");

  property p_unatt_idle;
    !attached |-> (!vbus_src_en && !vconn_en && !host_role);
  endproperty
  a_unatt_idle: assert property (p_unatt_idle) else $error("supply or host role while unattached");

  property p_src_attach;
    ($rose(vbus_src_en) && !$past(attached)) |-> (attached && vconn_en && host_role && power_src);
  endproperty
  a_src_attach: assert property (p_src_attach) else $error("source attach incomplete");

  property p_try_once;
    s_try_left |=> ((state != CCRL_TRY_SRC) && (state != CCRL_TRY_SNK));
  endproperty
  a_try_once: assert property (p_try_once) else $error("role try repeated");

  property p_pr_swap;
    s_pr_swap_snk |=> (power_src && vbus_src_en && $stable(vconn_en) && $stable(host_role));
  endproperty
  a_pr_swap: assert property (p_pr_swap) else $error("power swap changed wrong roles");

  property p_dr_swap;
    (attached && dr_swap_done && !vconn_swap_done && (next_state == state)) |=>
      ((host_role != $past(host_role)) && $stable(power_src) && $stable(vconn_en) && $stable(cc1_pull_up));
  endproperty
  a_dr_swap: assert property (p_dr_swap) else $error("data swap changed wrong roles");

  property p_limit_sink_only;
    (!attached || power_src) |-> (current_limit == CUR_NONE);
  endproperty
  a_limit_sink_only: assert property (p_limit_sink_only) else $error("current limit outside sink");

endmodule : ccrl_role_logic

`default_nettype wire

// ==== verif/ccrl_far_port.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// far-end port model
// ****
module ccrl_far_port (
  input wire logic [1:0] mode,
  input wire logic flip,
  input wire logic [1:0] level,
  input wire logic vbus_on,
  input wire logic [1:0] pu,
  input wire logic [1:0] pd,
  input wire logic our_vbus,
  output logic [1:0] rp_seen,
  output logic [1:0] rd_seen,
  output logic [1:0] rp_lvl1,
  output logic [1:0] rp_lvl2,
  output logic vbus
);
  logic [1:0] pin;
  assign pin = flip ? 2'h2 : 2'h1;
  assign rp_seen = (mode == 2'h2) ? (pin & pd) : 2'h0;
  assign rd_seen = (mode == 2'h1) ? (pin & pu) : 2'h0;
  assign rp_lvl1 = rp_seen[0] ? level : ~level;
  assign rp_lvl2 = rp_seen[1] ? level : ~level;
  assign vbus = our_vbus | (vbus_on & |rp_seen);
endmodule : ccrl_far_port
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// role logic bench
// ****
module tb;
  import ccrl_pkg::*;
  localparam int PER = 600;
  localparam int PCT = 50;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic drp_en = 1'h0;
  logic force_unattach = 1'h0;
  logic pr_swap_done = 1'h0;
  logic dr_swap_done = 1'h0;
  logic vconn_swap_done = 1'h0;
  logic vbus_on = 1'h0;
  logic p_flip = 1'h1;
  ccrl_pref_type pref = CCRL_PREF_NONE;
  logic [1:0] p_mode = 2'h2;
  logic [1:0] p_level = 2'h2;
  logic [1:0] rp_seen, rd_seen, lvl1, lvl2, current_limit;
  logic vbus_present, cc1_pull_down, cc2_pull_down, cc1_pull_up, cc2_pull_up, vbus_src_en, vconn_en;
  logic ss_flip, pd_en, pd_cc2, attached, host_role, power_src;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;

  ccrl_role_logic #(.PERIOD_CYCLES(PER), .SRC_PCT(PCT)) i_ccrl_role_logic (
    .sys_clk, .rst_n, .drp_en, .pref, .vbus_present, .cc1_rp_seen(rp_seen[0]), .cc2_rp_seen(rp_seen[1]),
    .cc1_rp_level(lvl1), .cc2_rp_level(lvl2), .cc1_rd_seen(rd_seen[0]), .cc2_rd_seen(rd_seen[1]),
    .pd_capable(1'h1), .force_unattach, .pr_swap_done, .dr_swap_done, .vconn_swap_done, .cc1_pull_down,
    .cc2_pull_down, .cc1_pull_up, .cc2_pull_up, .vbus_src_en, .vconn_en, .ss_flip, .current_limit, .pd_en,
    .pd_cc2, .attached, .host_role, .power_src);

  ccrl_far_port i_ccrl_far_port (.mode(p_mode), .flip(p_flip), .level(p_level), .vbus_on,
    .pu({cc2_pull_up, cc1_pull_up}), .pd({cc2_pull_down, cc1_pull_down}), .our_vbus(vbus_src_en),
    .rp_seen, .rd_seen, .rp_lvl1(lvl1), .rp_lvl2(lvl2), .vbus(vbus_present));

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic cycles(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cycles

  task automatic pulse(input logic [3:0] w);
    {force_unattach, vconn_swap_done, dr_swap_done, pr_swap_done} = w;
    @(negedge sys_clk);
    {force_unattach, vconn_swap_done, dr_swap_done, pr_swap_done} = 4'h0;
    cycles(2);
  endtask : pulse

  task automatic wait_att(input int lim);
    for (int k = 0; k < lim && attached !== 1'h1; k++) begin
      @(negedge sys_clk);
    end
    chk("attached", 4'h1, {3'h0, attached});
  endtask : wait_att

  task automatic count_up(output int m, output logic v);
    m = 0;
    v = 1'h0;
    repeat (PER) begin
      m += (cc1_pull_up === 1'h1);
      v |= (vbus_src_en !== 1'h0);
      @(negedge sys_clk);
    end
  endtask : count_up

  task automatic restart(input logic d, input logic [1:0] md, input ccrl_pref_type pf);
    rst_n = 1'h0;
    drp_en = d;
    p_mode = md;
    pref = pf;
    cycles(3);
    rst_n = 1'h1;
  endtask : restart

  initial begin
    int m;
    logic v;
    restart(1'h0, 2'h2, CCRL_PREF_NONE);
    chk("pulls", 4'hC, {cc1_pull_down, cc2_pull_down, cc1_pull_up, cc2_pull_up});
    chk("src_off", {2'h0, CUR_NONE}, {vbus_src_en, vconn_en, current_limit});
    cycles(200);
    chk("no_vbus", 4'h0, {3'h0, attached});
    pulse(4'h2);
    chk("early_swap", 4'h0, {3'h0, host_role});
    vbus_on = 1'h1;
    wait_att(100);
    chk("orient", 4'hF, {ss_flip, pd_cc2, pd_en, cc1_pull_down});
    chk("roles", 4'h2, {host_role, power_src, current_limit});
    p_level = 2'h1;
    cycles(4);
    chk("limit", 4'h1, {2'h0, current_limit});
    pulse(4'h2);
    chk("dr_swap", 4'h9, {host_role, power_src, vconn_en, cc2_pull_down});
    pulse(4'h4);
    chk("vconn_swap", 4'hB, {host_role, power_src, vconn_en, cc2_pull_down});
    pr_swap_done = 1'h1;
    @(negedge sys_clk);
    pr_swap_done = 1'h0;
    p_mode = 2'h1;
    cycles(4);
    chk("pr_swap", 4'hF, {power_src, vbus_src_en, vconn_en, host_role});
    chk("pr_terms", 4'hC, {attached, cc2_pull_up, cc2_pull_down, 1'h0});
    pulse(4'h8);
    chk("force_wait", 4'h1, {3'h0, attached});
    cycles(PER);
    chk("force_done", 4'h0, {3'h0, attached});
    restart(1'h1, 2'h0, CCRL_PREF_NONE);
    count_up(m, v);
    chk("src_share", 4'h1, {3'h0, m == PER * PCT / 100});
    chk("idle_vbus", 4'h0, {3'h0, v});
    p_mode = 2'h1;
    p_flip = 1'h0;
    wait_att(3 * PER);
    chk("src_attach", 4'hF, {vbus_src_en, vconn_en, host_role, power_src});
    count_up(m, v);
    chk("src_hold", 4'h1, {3'h0, m == PER});
    restart(1'h1, 2'h2, CCRL_PREF_NONE);
    wait_att(3 * PER);
    chk("snk_attach", 4'h2, {power_src, host_role, cc1_pull_down, ss_flip});
    count_up(m, v);
    chk("snk_hold", 4'h1, {3'h0, m == 0});
    restart(1'h1, 2'h2, CCRL_PREF_SRC);
    wait_att(9000);
    cycles(TRY_WAIT_CYCLES + PER);
    chk("try_src", 4'h2, {2'h0, attached, power_src});
    restart(1'h1, 2'h1, CCRL_PREF_SNK);
    wait_att(9000);
    cycles(TRY_WAIT_CYCLES + PER);
    chk("try_snk", 4'h3, {2'h0, attached, power_src});
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
